// [common/ram_port_defs.svh]
// Constants for the on-chip RAM port: address decode, sizes and reset values.
`ifndef RAM_PORT_DEFS_SVH
`define RAM_PORT_DEFS_SVH

`define AREA7_TAG        4'hF
`define AREA_TAG_MSB     27
`define AREA_TAG_LSB     24
`define RAM_BYTES_LARGE  8192
`define RAM_BYTES_SMALL  4096
`define RAM_AW_LARGE     13
`define RAM_AW_SMALL     12
`define RAM_BASE_LARGE   28'hFFFE000
`define RAM_BASE_SMALL   28'hFFFF000
`define RDATA_RESET      32'h00000000

`endif

// [common/ram_port_pkg.sv]
// Types shared by the on-chip RAM port and its testbench.
package ram_port_pkg;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_LONG = 2'h2
	} access_size_e;

	typedef struct packed {
		logic         valid;
		logic         write;
		access_size_e size;
		logic [27:0]  addr;
		logic [31:0]  wdata;
	} bus_req_s;

	typedef struct packed {
		logic        ack;
		logic        error;
		logic [31:0] rdata;
	} bus_rsp_s;

	typedef enum logic [1:0] {
		OWNER_NONE = 2'h1,
		OWNER_DMA  = 2'h2
	} owner_e;

endpackage

// [hdl/ram_lane.sv]
// One byte lane of the RAM array, written only when its strobe is set.
`timescale 1ns/100ps

module ram_lane #(
	parameter int AW = 13
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] index,
	input  wire logic [7:0]    wdata,
	output      logic [7:0]    rdata
);

	logic [7:0] mem_reg [0:(1<<AW)-1];

	// Storage has no reset, so contents survive reset and any low-power mode.
	always_ff @(posedge clk) begin
		if (we) begin
			mem_reg[index] <= wdata;
		end
	end

	assign rdata = mem_reg[index];

endmodule

// [hdl/onchip_ram_port.sv]
// On-chip static RAM with a processor port and a DMA port on a 32-bit path.
// What this block does
// - Array holds 8 kbytes or 4 kbytes, chosen by a build parameter.
// - Both processor and DMA controller reach the RAM over 32-bit data.
// - Processor may read and write bytes, words and longwords.
// - DMA controller may use bytes and words only, never longwords.
// - Processor accesses complete in one clock state; a DMA access does too unless the processor requests in the same cycle.
// - Contents are kept unchanged through sleep and standby.
// - RAM answers at its base range at the top of area 7.
// - Area 7 holds repeated RAM images in blocks of the RAM size.
// - A shadow access behaves exactly like the matching base access.
`timescale 1ns/100ps
`include "ram_port_defs.svh"

module onchip_ram_port #(
	parameter bit LARGE = 1'b1
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire ram_port_pkg::bus_req_s cpu_req,
	output      ram_port_pkg::bus_rsp_s cpu_rsp,
	input  wire ram_port_pkg::bus_req_s dma_req,
	output      ram_port_pkg::bus_rsp_s dma_rsp
);

	// ******************************************************************
	// Geometry
	// ******************************************************************
	localparam int AW = LARGE ? `RAM_AW_LARGE : `RAM_AW_SMALL;

	// ******************************************************************
	// Decode and arbitration
	// ******************************************************************
	logic                  cpu_hit;
	logic                  dma_hit;
	logic                  dma_ok;
	logic                  cpu_go;
	logic                  dma_go;
	logic                  sel_dma;
	ram_port_pkg::bus_req_s req;
	logic [3:0]            lane_we;
	logic [31:0]           lane_wdata;
	logic [AW-1:0]         index;
	logic [31:0]           rdata;

	// Whole of area 7 maps onto the RAM; shadows alias the base image.
	assign cpu_hit = cpu_req.valid && cpu_req.addr[`AREA_TAG_MSB:`AREA_TAG_LSB] == `AREA7_TAG;
	assign dma_hit = dma_req.valid && dma_req.addr[`AREA_TAG_MSB:`AREA_TAG_LSB] == `AREA7_TAG;
	assign dma_ok  = dma_req.size != ram_port_pkg::SIZE_LONG;
	// The processor wins a simultaneous request; the DMA side sees no ack and retries.
	assign cpu_go  = cpu_hit;
	assign dma_go  = dma_hit && dma_ok && !cpu_hit;
	assign sel_dma = dma_go;

	always_comb begin
		req        = sel_dma ? dma_req : cpu_req;
		index      = req.addr[AW-1:0];
		lane_we    = 4'h0;
		lane_wdata = req.wdata;
		if ((cpu_go || dma_go) && req.write) begin
			unique case (req.size)
				ram_port_pkg::SIZE_BYTE: begin
					lane_we    = 4'h1 << req.addr[1:0];
					lane_wdata = {4{req.wdata[7:0]}};
				end
				ram_port_pkg::SIZE_WORD: begin
					lane_we    = req.addr[1] ? 4'hC : 4'h3;
					lane_wdata = {2{req.wdata[15:0]}};
				end
				default: begin
					lane_we = 4'hF;
				end
			endcase
		end
	end

	// ******************************************************************
	// Byte lanes
	// ******************************************************************
	// Each lane holds a quarter of the array, so the four together make the RAM size.
	for (genvar g = 0; g < 4; g++) begin : g_lane
		ram_lane #(
			.AW(AW-2)
		) u_lane (
			.clk  (clk),
			.we   (lane_we[g]),
			.index(index[AW-1:2]),
			.wdata(lane_wdata[8*g +: 8]),
			.rdata(rdata[8*g +: 8])
		);
	end

	// ******************************************************************
	// Response registers
	// ******************************************************************
	ram_port_pkg::bus_rsp_s cpu_rsp_reg;
	ram_port_pkg::bus_rsp_s cpu_rsp_next;
	ram_port_pkg::bus_rsp_s dma_rsp_reg;
	ram_port_pkg::bus_rsp_s dma_rsp_next;
	logic [31:0]            rd_aligned;

	// Read data is returned right-justified for bytes and words.
	always_comb begin
		unique case (req.size)
			ram_port_pkg::SIZE_BYTE: rd_aligned = {24'h000000, rdata[8*req.addr[1:0] +: 8]};
			ram_port_pkg::SIZE_WORD: rd_aligned = {16'h0000, req.addr[1] ? rdata[31:16] : rdata[15:0]};
			default:                 rd_aligned = rdata;
		endcase
	end

	always_comb begin
		cpu_rsp_next       = '0;
		dma_rsp_next       = '0;
		cpu_rsp_next.ack   = cpu_go;
		cpu_rsp_next.rdata = (cpu_go && !cpu_req.write) ? rd_aligned : `RDATA_RESET;
		// A refused longword that also loses to the processor is simply not answered yet.
		dma_rsp_next.ack   = dma_go || (dma_hit && !dma_ok && !cpu_hit);
		dma_rsp_next.error = dma_hit && !dma_ok && !cpu_hit;
		dma_rsp_next.rdata = (dma_go && !dma_req.write) ? rd_aligned : `RDATA_RESET;
	end

	// Reset clears only the answer; the array itself is untouched.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cpu_rsp_reg <= '0;
			dma_rsp_reg <= '0;
		end else begin
			cpu_rsp_reg <= cpu_rsp_next;
			dma_rsp_reg <= dma_rsp_next;
		end
	end

	assign cpu_rsp = cpu_rsp_reg;
	assign dma_rsp = dma_rsp_reg;

endmodule

// [tb/onchip_ram_port_monitor.sv]
// Checker for the on-chip RAM port.
`timescale 1ns/100ps
module onchip_ram_port_monitor #(
	parameter bit LARGE = 1'b1
) (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire ram_port_pkg::bus_req_s cpu_req,
	input wire ram_port_pkg::bus_rsp_s cpu_rsp,
	input wire ram_port_pkg::bus_req_s dma_req,
	input wire ram_port_pkg::bus_rsp_s dma_rsp
);
	localparam int AW = LARGE ? 13 : 12;
	wire logic ch = cpu_req.valid && cpu_req.addr[27:24] == 4'hF;
	wire logic dh = dma_req.valid && dma_req.addr[27:24] == 4'hF && !ch;
	wire logic dl = dma_req.size == ram_port_pkg::SIZE_LONG;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_cpu_one_state: assert property (ch |=> cpu_rsp.ack) else $error("cpu ack late");
	a_cpu_outside: assert property (!ch |=> !cpu_rsp.ack) else $error("cpu stray ack");
	a_cpu_no_error: assert property (!cpu_rsp.error) else $error("cpu error");
	a_dma_long_err: assert property (dh && dl |=> dma_rsp.error && dma_rsp.rdata == 32'h0)
		else $error("dma long");
	a_dma_one_state: assert property (dh && !dl |=> dma_rsp.ack && !dma_rsp.error) else $error("dma ack");
	a_dma_yields: assert property (!dh |=> !dma_rsp.ack) else $error("dma stray ack");
	a_err_cause: assert property (dma_rsp.error |-> $past(dl)) else $error("dma bad error");
	a_shadow_read: assert property (ch && cpu_req.write ##1 ch && !cpu_req.write && cpu_req.size == 2'h2
		&& $past(cpu_req.size) == 2'h2 && cpu_req.addr[AW-1:2] == $past(cpu_req.addr[AW-1:2])
		|=> cpu_rsp.rdata == $past(cpu_req.wdata, 2)) else $error("shadow data");
endmodule

// [tb/dma_master.sv]
// DMA controller model: one-cycle requests, retried until answered.
`timescale 1ns/100ps
module dma_master (
	input  wire logic                   clk,
	input  wire logic                   go,
	input  wire ram_port_pkg::bus_req_s cmd,
	input  wire ram_port_pkg::bus_rsp_s rsp,
	output      ram_port_pkg::bus_req_s req,
	output      ram_port_pkg::bus_rsp_s got,
	output      logic                   done
);
	ram_port_pkg::bus_req_s cur;
	logic                   wait_r;
	initial begin
		req = '0;
		wait_r = 0;
		done = 0;
	end
	// Released lines show inverted values so stale data cannot pass.
	always @(posedge clk) begin
		done <= 1'b0;
		if (req.valid) req <= {1'b0, ~cur[62:0]};
		else if (go) begin
			cur <= cmd;
			req <= cmd;
			wait_r <= 1'b1;
		end else if (wait_r && rsp.ack) begin
			wait_r <= 1'b0;
			got <= rsp;
			done <= 1'b1;
		end else if (wait_r) req <= cur;
	end
endmodule

// [tb/tb.sv]
// Testbench for the on-chip RAM port.
`timescale 1ns/100ps
module tb;
	logic                   clk, rst_n, dgo, ddone, k;
	ram_port_pkg::bus_req_s creq, dcmd, dreq;
	ram_port_pkg::bus_rsp_s crsp, drsp, g;
	logic [31:0]            r;
	int                     miscompares, tests_run;
	onchip_ram_port onchip_ram_port_i (.clk(clk), .rst_n(rst_n), .cpu_req(creq), .cpu_rsp(crsp),
		.dma_req(dreq), .dma_rsp(drsp));
	dma_master dma_master_i (.clk(clk), .go(dgo), .cmd(dcmd), .rsp(drsp), .req(dreq), .got(g), .done(ddone));
	task chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cpu(input logic [33:0] ws, input logic [27:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 creq = {1'b1, ws[0], ws[33:32], a, d};
		@(posedge clk);
		#1 creq.valid = 1'b0;
		k = crsp.ack;
		r = crsp.rdata;
	endtask
	task dma(input logic [33:0] ws, input logic [27:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 dcmd = {1'b1, ws[0], ws[33:32], a, d};
		dgo = 1'b1;
		@(posedge clk);
		#1 dgo = 1'b0;
		repeat (20) begin
			if (!ddone) begin
				@(posedge clk);
				#1;
			end
		end
		chk(ddone, 1);
	endtask
	task t_lanes;
		cpu(34'h200000001, 28'hFFFE000, 32'h11223344);
		cpu(34'h000000001, 28'hFFFE001, 32'h000000AA);
		cpu(34'h100000001, 28'hFFFE002, 32'h0000BEEF);
		cpu(34'h200000000, 28'hFFFE000, 0);
		chk(r, 32'hBEEFAA44);
		cpu(34'h000000000, 28'hFFFE003, 0);
		chk(r, 32'h000000BE);
		$display("t_lanes done");
	endtask
	task t_shadow;
		cpu(34'h200000001, 28'hFFFF010, 32'h77);
		@(posedge clk);
		#1 creq = {1'b1, 1'b1, 2'h2, 28'hFFFE010, 32'h5A5AC3C3};
		@(posedge clk);
		#1 creq = {1'b1, 1'b0, 2'h2, 28'hF000010, 32'h0};
		cpu(34'h200000000, 28'hF3FE010, 0);
		chk(r, 32'h5A5AC3C3);
		cpu(34'h200000000, 28'h0FFE010, 0);
		chk(k, 0);
		$display("t_shadow done");
	endtask
	task t_dma;
		dma(34'h100000001, 28'hFFFE020, 32'h1234);
		fork
			begin
				@(posedge clk);
				cpu(34'h200000000, 28'hFFFE020, 0);
			end
			dma(34'h000000000, 28'hFFFE021, 0);
		join
		chk(r, 32'h00001234);
		chk(g.rdata, 32'h12);
		dma(34'h200000001, 28'hFFFE020, 32'h0);
		chk(g.error, 1);
		cpu(34'h200000000, 28'hFFFE020, 0);
		chk(r, 32'h1234);
		$display("t_dma done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000 miscompares++;
		final_report;
	end
	initial begin
		{rst_n, dgo, creq, dcmd} = '0;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		t_lanes;
		t_shadow;
		t_dma;
		final_report;
	end
endmodule
bind onchip_ram_port onchip_ram_port_monitor #(.LARGE(LARGE)) onchip_ram_port_monitor_i (.clk(clk), .rst_n(rst_n),
	.cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .dma_req(dma_req), .dma_rsp(dma_rsp));
